// ### verilog/rcp_defs.svh
`ifndef RCP_DEFS_SVH
`define RCP_DEFS_SVH

// command word layout
`define RCP_WORD_W 16
`define RCP_CMD_HI 13
`define RCP_CMD_LO 10
`define RCP_DATA_HI 9
`define RCP_DATA_LO 0
`define RCP_ADDR_HI 5

// control register layout and reset values
`define RCP_CTRL_SUCCESS_BIT 3
`define RCP_CTRL_PERMIT_BIT 1
`define RCP_CTRL_PROG_EN_BIT 0
`define RCP_PERMIT_RST 1'b0
`define RCP_PROG_EN_RST 1'b0
`define RCP_SUCCESS_RST 1'b0
`define RCP_SHUTDOWN_RST 1'b0

// wiper and store
`define RCP_MIDSCALE 10'h200
`define RCP_FIRST_LOC 6'h01
`define RCP_LAST_LOC 6'h32
`define RCP_NONE_LOC 6'h00
`define RCP_TOL_MSB_LOC 6'h39
`define RCP_TOL_LSB_LOC 6'h3A

// timing
`define RCP_CLK_HZ 100000000
`define RCP_PROG_TIME_MS 350
`define RCP_PROG_CYCLES ((`RCP_PROG_TIME_MS * 64'd`RCP_CLK_HZ) / 64'd1000)

`endif

// ### verilog/rcp_pkg.sv
package rcp_pkg;

  typedef enum logic [3:0] {
    RCP_CMD_IDLE = 4'h0,
    RCP_CMD_WIPER_WR = 4'h1,
    RCP_CMD_WIPER_RD = 4'h2,
    RCP_CMD_STORE = 4'h3,
    RCP_CMD_SW_RESET = 4'h4,
    RCP_CMD_MEM_RD = 4'h5,
    RCP_CMD_LAST_RD = 4'h6,
    RCP_CMD_CTRL_WR = 4'h7,
    RCP_CMD_CTRL_RD = 4'h8,
    RCP_CMD_SHUTDOWN = 4'h9
  } rcp_cmd_t;

  typedef enum logic {
    RCP_ST_READY,
    RCP_ST_PROG
  } rcp_state_t;

endpackage : rcp_pkg

// ### verilog/rcp_core.sv
`timescale 1ns/1ns
`include "rcp_defs.svh"
// Summary of operation
// [R1] after reset wiper writes and store programming are refused until enabled
// [R2] permit bit low freezes the wiper except reload by soft or pin reset
// [R3] soft reset command reloads wiper from the last saved store value
// [R4] control write copies operand bit 1 to permit, bit 0 to program enable
// [R5] program enable resets low; store programming refused while it is low
// [R6] command code taken from word bits 13..10, operand from bits 9..0
// [R7] code 0 changes nothing but still shifts out the prepared result
// [R8] code 1 loads the operand into the wiper when permitted
// [R9] code 2 prepares the wiper value for the next frame
// [R10] code 3 copies the wiper into the next free store slot if enabled
// [R11] code 5 returns the store slot named by operand bits 5..0 next frame
// [R12] code 6 returns address of last programmed slot in six low bits
// [R13] code 8 returns the control register in the low four bits
// [R14] code 9 enters shutdown on operand bit 0 high, leaves it on low
// [R15] each frame returns the last accepted read result or echoes the last accepted word; words dropped while programming change nothing
// [R16] control word: success at bit 3, permit bit 1, enable bit 0, rest zero
// [R17] success flag resets low and is set when a store program completes
// [R18] when locked the wiper holds last saved value or midscale if none; clearing permit here keeps the current wiper value
// [R19] slot 0 reserved; slots 1..50 hold saved values in programming order
// [R20] slots 0x39 and 0x3A hold factory tolerance integer and fraction
// [R21] during store programming the shift register is locked to commands
// [R22] programming starts at slot 1 and advances by one per store command
// [R23] the command word is 16 bits, MSB first, top two bits unused
// [R24] once all fifty slots are used store commands are ignored, success clear
module rcp_core #(
  parameter longint unsigned PROG_CYCLES = `RCP_PROG_CYCLES,
  parameter logic [9:0] TOL_MSB = 10'h000,
  parameter logic [9:0] TOL_LSB = 10'h000
) (
  // system
  input wire logic ref_clk,
  input wire logic rst_n,
  // hardware reload pin, asynchronous
  input wire logic reload_pin_n,
  // serial link
  input wire logic link_clk,
  input wire logic link_frame,
  input wire logic link_data_in,
  output logic serial_readback_out,
  // analog side and status
  output logic [9:0] wiper_setting_register,
  output logic shutdown_active,
  output logic store_busy,
  output logic wiper_write_permit,
  output logic store_program_enable,
  output logic program_success_flag
);
  import rcp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // link domain
  logic link_rst_s1_ff;
  logic link_rst_n_ff;
  logic [3:0] link_cnt_ff;
  logic [15:0] link_rx_ff;
  logic [15:0] link_word_ff;
  logic link_tgl_ff;
  logic [15:0] link_tx_ff;
  logic [15:0] link_hold_ff;
  logic otg_s1_ff;
  logic otg_s2_ff;
  logic otg_s3_ff;
  logic [15:0] out_word_ff;
  logic out_tgl_ff;

  always_ff @(posedge link_clk) begin
    link_rst_s1_ff <= rst_n;
    link_rst_n_ff <= link_rst_s1_ff;
  end

  // bit counter and receive shifter, MSB first
  always_ff @(posedge link_clk) begin
    if (!link_rst_n_ff) begin
      link_cnt_ff <= 4'h0;
      link_rx_ff <= 16'h0000;
    end else if (!link_frame) begin
      link_cnt_ff <= 4'h0;
    end else begin
      link_cnt_ff <= link_cnt_ff + 4'h1;
      link_rx_ff <= {link_rx_ff[14:0], link_data_in}; // R23
    end
  end

  // completed word is held stable until the next frame completes
  always_ff @(posedge link_clk) begin
    if (!link_rst_n_ff) begin
      link_word_ff <= 16'h0000;
      link_tgl_ff <= 1'b0;
    end else if (link_frame && link_cnt_ff == 4'hF) begin
      link_word_ff <= {link_rx_ff[14:0], link_data_in}; // R23
      link_tgl_ff <= ~link_tgl_ff;
    end
  end

  // answer word crosses in by toggle plus held data
  always_ff @(posedge link_clk) begin
    if (!link_rst_n_ff) begin
      otg_s1_ff <= 1'b0;
      otg_s2_ff <= 1'b0;
      otg_s3_ff <= 1'b0;
      link_hold_ff <= 16'h0000;
    end else begin
      otg_s1_ff <= out_tgl_ff;
      otg_s2_ff <= otg_s1_ff;
      otg_s3_ff <= otg_s2_ff;
      if (otg_s2_ff != otg_s3_ff) begin
        link_hold_ff <= out_word_ff;
      end
    end
  end

  // transmit shifter: loaded between frames, shifted on each rising link_clk edge while the frame is high
  always_ff @(posedge link_clk) begin
    if (!link_rst_n_ff) begin
      link_tx_ff <= 16'h0000;
    end else if (!link_frame) begin
      link_tx_ff <= link_hold_ff;
    end else begin
      link_tx_ff <= {link_tx_ff[14:0], 1'b0}; // R15
    end
  end

  assign serial_readback_out = link_tx_ff[15];

  ////////////////////////////////////////////////////////////////////////
  // crossings into ref_clk
  logic rtg_s1_ff;
  logic rtg_s2_ff;
  logic rtg_s3_ff;
  logic rld_s1_ff;
  logic rld_s2_ff;
  logic rld_s3_ff;
  logic word_valid;
  logic reload_pulse;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rtg_s1_ff <= 1'b0;
      rtg_s2_ff <= 1'b0;
      rtg_s3_ff <= 1'b0;
      rld_s1_ff <= 1'b1;
      rld_s2_ff <= 1'b1;
      rld_s3_ff <= 1'b1;
    end else begin
      rtg_s1_ff <= link_tgl_ff;
      rtg_s2_ff <= rtg_s1_ff;
      rtg_s3_ff <= rtg_s2_ff;
      rld_s1_ff <= reload_pin_n;
      rld_s2_ff <= rld_s1_ff;
      rld_s3_ff <= rld_s2_ff;
    end
  end

  assign word_valid = rtg_s2_ff != rtg_s3_ff;
  assign reload_pulse = rld_s3_ff && !rld_s2_ff;

  ////////////////////////////////////////////////////////////////////////
  // decode
  logic [15:0] word;
  rcp_cmd_t cmd;
  logic [9:0] operand;
  logic [5:0] mem_sel;
  logic accept;

  assign word = link_word_ff;
  assign cmd = rcp_cmd_t'(word[`RCP_CMD_HI:`RCP_CMD_LO]); // R6
  assign operand = word[`RCP_DATA_HI:`RCP_DATA_LO]; // R6
  assign mem_sel = operand[`RCP_ADDR_HI:0]; // R11

  ////////////////////////////////////////////////////////////////////////
  // store and programming sequencer
  logic [9:0] store_mem [0:63];
  logic [5:0] last_loc_ff;
  rcp_state_t state_ff;
  longint unsigned prog_cnt_ff;
  logic [9:0] prog_val_ff;
  logic [9:0] wiper_ff;
  logic permit_ff;
  logic prog_en_ff;
  logic success_ff;
  logic shutdown_ff;
  logic store_go;
  logic prog_done;
  logic [9:0] saved_val;

  // words arriving during programming are dropped
  assign accept = word_valid && state_ff == RCP_ST_READY; // R21
  assign store_go = accept && cmd == RCP_CMD_STORE && prog_en_ff // R5 R10
    && last_loc_ff != `RCP_LAST_LOC; // R24
  assign prog_done = state_ff == RCP_ST_PROG && prog_cnt_ff == 64'd1;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= RCP_ST_READY;
      prog_cnt_ff <= 64'd0;
      prog_val_ff <= 10'h000;
    end else begin
      case (state_ff)
        RCP_ST_READY: begin
          if (store_go) begin
            state_ff <= RCP_ST_PROG; // R21
            prog_cnt_ff <= PROG_CYCLES;
            prog_val_ff <= wiper_ff; // R10
          end
        end
        RCP_ST_PROG: begin
          prog_cnt_ff <= prog_cnt_ff - 64'd1;
          if (prog_done) begin
            state_ff <= RCP_ST_READY;
          end
        end
        default: state_ff <= RCP_ST_READY;
      endcase
    end
  end

  // slots are written in order starting at slot one
  always_ff @(posedge ref_clk) begin
    if (prog_done) begin
      store_mem[last_loc_ff + 6'h01] <= prog_val_ff; // R19 R22
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      last_loc_ff <= `RCP_NONE_LOC;
    end else if (prog_done) begin
      last_loc_ff <= last_loc_ff + 6'h01; // R22
    end
  end

  assign saved_val = (last_loc_ff == `RCP_NONE_LOC) ? `RCP_MIDSCALE // R18
    : store_mem[last_loc_ff];

  ////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      permit_ff <= `RCP_PERMIT_RST; // R1
      prog_en_ff <= `RCP_PROG_EN_RST; // R1 R5
    end else if (accept && cmd == RCP_CMD_CTRL_WR) begin
      permit_ff <= operand[`RCP_CTRL_PERMIT_BIT]; // R4
      prog_en_ff <= operand[`RCP_CTRL_PROG_EN_BIT]; // R4
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      success_ff <= `RCP_SUCCESS_RST; // R17
    end else if (prog_done) begin
      success_ff <= 1'b1; // R17
    end else if (accept && cmd == RCP_CMD_STORE && prog_en_ff) begin
      success_ff <= 1'b0; // R24
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wiper and shutdown
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wiper_ff <= `RCP_MIDSCALE; // R18
    end else if (reload_pulse) begin
      wiper_ff <= saved_val; // R2
    end else if (accept && cmd == RCP_CMD_SW_RESET) begin
      wiper_ff <= saved_val; // R3
    end else if (accept && cmd == RCP_CMD_WIPER_WR && permit_ff) begin
      wiper_ff <= operand; // R8 R2
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shutdown_ff <= `RCP_SHUTDOWN_RST;
    end else if (reload_pulse) begin
      shutdown_ff <= 1'b0;
    end else if (accept && cmd == RCP_CMD_SW_RESET) begin
      shutdown_ff <= 1'b0;
    end else if (accept && cmd == RCP_CMD_SHUTDOWN) begin
      shutdown_ff <= operand[0]; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // answer word for the next frame
  function automatic logic [9:0] rcp_mem_read(input logic [5:0] sel,
                                              input logic [5:0] last);
    logic [9:0] val;
    val = 10'h000;
    if (sel == `RCP_TOL_MSB_LOC) begin
      val = TOL_MSB; // R20
    end else if (sel == `RCP_TOL_LSB_LOC) begin
      val = TOL_LSB; // R20
    end else if (sel >= `RCP_FIRST_LOC && sel <= last) begin
      val = store_mem[sel]; // R19
    end
    return val;
  endfunction : rcp_mem_read

  logic [9:0] ctrl_word;
  logic [15:0] nxt_out_word;

  always_comb begin
    ctrl_word = 10'h000; // R16
    ctrl_word[`RCP_CTRL_SUCCESS_BIT] = success_ff; // R16
    ctrl_word[`RCP_CTRL_PERMIT_BIT] = permit_ff; // R16
    ctrl_word[`RCP_CTRL_PROG_EN_BIT] = prog_en_ff; // R16
  end

  always_comb begin
    case (cmd)
      RCP_CMD_WIPER_RD: nxt_out_word = {6'h00, wiper_ff}; // R9
      RCP_CMD_MEM_RD: nxt_out_word = {6'h00, rcp_mem_read(mem_sel, last_loc_ff)}; // R11
      RCP_CMD_LAST_RD: nxt_out_word = {10'h000, last_loc_ff}; // R12
      RCP_CMD_CTRL_RD: nxt_out_word = {6'h00, ctrl_word}; // R13
      default: nxt_out_word = word; // R15
    endcase
  end

  // each accepted word sets the answer carried by the following frame
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_word_ff <= 16'h0000;
      out_tgl_ff <= 1'b0;
    end else if (accept) begin
      // an idle word is echoed like any other non-read word
      // while its own frame still carries the earlier answer out
      out_word_ff <= nxt_out_word; // R7 R15
      out_tgl_ff <= ~out_tgl_ff;
    end
  end

  assign wiper_setting_register = wiper_ff;
  assign shutdown_active = shutdown_ff;
  assign store_busy = state_ff == RCP_ST_PROG;
  assign wiper_write_permit = permit_ff;
  assign store_program_enable = prog_en_ff;
  assign program_success_flag = success_ff;

endmodule : rcp_core

// ### bench/rcp_core_props.sv
`timescale 1ns/1ns
module rcp_core_props #(
  parameter longint unsigned PROG_CYCLES = 20
) (
  // system
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reload_pin_n,
  // serial link
  input wire logic link_clk,
  input wire logic link_frame,
  input wire logic link_data_in,
  input wire logic serial_readback_out,
  // wiper and status
  input wire logic [9:0] wiper_setting_register,
  input wire logic shutdown_active,
  input wire logic store_busy,
  input wire logic wiper_write_permit,
  input wire logic store_program_enable,
  input wire logic program_success_flag
);
  logic [31:0] busy_cnt_ff;
  // length of the running store cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !store_busy) busy_cnt_ff <= 32'h0;
    else busy_cnt_ff <= busy_cnt_ff + 32'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  property p_rst_state;
    $rose(rst_n) |-> wiper_setting_register == 10'h200 && !wiper_write_permit
      && !store_program_enable && !program_success_flag && !store_busy;
  endproperty
  a_rst_state: assert property (p_rst_state)
    else $error("state after reset wrong");
  property p_busy_needs_en;
    $rose(store_busy) |-> store_program_enable;
  endproperty
  a_busy_needs_en: assert property (p_busy_needs_en)
    else $error("store started while disabled");
  property p_busy_len;
    $fell(store_busy) && $past(rst_n) |->
      busy_cnt_ff >= PROG_CYCLES - 1 && busy_cnt_ff <= PROG_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("store cycle length wrong");
  property p_done_success;
    $fell(store_busy) && $past(rst_n) |-> ##[0:2] program_success_flag;
  endproperty
  a_done_success: assert property (p_done_success)
    else $error("success not set after store");
  property p_busy_clear;
    store_busy && $past(store_busy) |-> !program_success_flag;
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("success high during store");
  property p_wiper_hold;
    store_busy && $past(store_busy) && reload_pin_n |-> $stable(wiper_setting_register);
  endproperty
  a_wiper_hold: assert property (p_wiper_hold)
    else $error("wiper moved during store");
  property p_ctrl_hold;
    store_busy && $past(store_busy) |-> $stable({wiper_write_permit, store_program_enable});
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control moved during store");
  property p_sd_hold;
    store_busy && $past(store_busy) && reload_pin_n |-> $stable(shutdown_active);
  endproperty
  a_sd_hold: assert property (p_sd_hold)
    else $error("shutdown moved during store");
endmodule : rcp_core_props
bind rcp_core rcp_core_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.ref_clk(ref_clk),
  .rst_n(rst_n), .reload_pin_n(reload_pin_n), .link_clk(link_clk), .link_frame(link_frame),
  .link_data_in(link_data_in), .serial_readback_out(serial_readback_out),
  .wiper_setting_register(wiper_setting_register), .shutdown_active(shutdown_active),
  .store_busy(store_busy), .wiper_write_permit(wiper_write_permit),
  .store_program_enable(store_program_enable), .program_success_flag(program_success_flag));

// ### bench/rcp_link_master.sv
`timescale 1ns/1ns
module rcp_link_master (
  // serial link
  input wire logic link_clk,
  input wire logic serial_readback_out,
  output logic link_frame,
  output logic link_data_in
);
  initial begin
    link_frame = 1'b0;
    link_data_in = 1'b1;
  end
  // whole frame msb first, then a frame-low gap for the answer to cross
  task automatic xfer(input logic [15:0] word, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      @(negedge link_clk);
      rx[i] = serial_readback_out;
      link_frame = 1'b1;
      link_data_in = word[i];
    end
    @(negedge link_clk);
    link_frame = 1'b0;
    // released line toggles so a stale bit is never mistaken for data
    repeat (8) begin
      link_data_in = ~link_data_in;
      @(negedge link_clk);
    end
  endtask : xfer
endmodule : rcp_link_master

// ### bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import rcp_pkg::*;
  localparam longint unsigned PROG = 60;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reload_pin_n = 1'b1;
  logic link_frame, link_data_in, serial_readback_out;
  logic shutdown_active, store_busy, wiper_write_permit, store_program_enable;
  logic program_success_flag;
  logic [9:0] wiper_setting_register;
  logic [15:0] rx;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  always #5 ref_clk = ~ref_clk;
  always #6 link_clk = ~link_clk;
  rcp_core #(.PROG_CYCLES(PROG), .TOL_MSB(10'h08A), .TOL_LSB(10'h0B0)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .reload_pin_n(reload_pin_n), .link_clk(link_clk),
    .link_frame(link_frame), .link_data_in(link_data_in),
    .serial_readback_out(serial_readback_out), .wiper_setting_register(wiper_setting_register),
    .shutdown_active(shutdown_active), .store_busy(store_busy),
    .wiper_write_permit(wiper_write_permit), .store_program_enable(store_program_enable),
    .program_success_flag(program_success_flag));
  rcp_link_master mst (.link_clk(link_clk), .serial_readback_out(serial_readback_out),
    .link_frame(link_frame), .link_data_in(link_data_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic send(input logic [15:0] w);
    mst.xfer(w, rx);
  endtask : send
  // read command, then an idle frame that carries its answer
  task automatic rd(input logic [15:0] w, input logic [15:0] exp);
    send(w);
    send(16'h0000);
    check(rx, exp);
  endtask : rd
  task automatic wait_idle;
    for (int n = 0; n < 200 && store_busy !== 1'b0; n++) @(negedge ref_clk);
    check({15'h0000, store_busy}, 16'h0000);
  endtask : wait_idle
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_locked;
    check({6'h00, wiper_setting_register}, 16'h0200);
    send(16'h0500);
    check({6'h00, wiper_setting_register}, 16'h0200);
    send(16'h0C00);
    check({15'h0000, store_busy}, 16'h0000);
    send(16'h2000);
    check(rx, 16'h0C00);
    send(16'h0000);
    check(rx, 16'h0000);
    $display("test locked done");
  endtask : t_locked
  task automatic t_enable;
    send(16'h1C03);
    check({14'h0000, wiper_write_permit, store_program_enable}, 16'h0003);
    send(16'h0500);
    check({6'h00, wiper_setting_register}, 16'h0100);
    check(rx, 16'h1C03);
    send(16'h0800);
    check(rx, 16'h0500);
    send(16'h0000);
    check(rx, 16'h0100);
    rd(16'h2000, 16'h0003);
    $display("test enable done");
  endtask : t_enable
  task automatic t_store;
    send(16'h0C00);
    check({15'h0000, store_busy}, 16'h0001);
    send(16'h07FF);
    check({6'h00, wiper_setting_register}, 16'h0100);
    wait_idle();
    check({15'h0000, program_success_flag}, 16'h0001);
    rd(16'h1800, 16'h0001);
    rd(16'h1401, 16'h0100);
    rd(16'h1400, 16'h0000);
    rd(16'h2000, 16'h000B);
    $display("test store done");
  endtask : t_store
  task automatic t_reset;
    send(16'h06AA);
    check({6'h00, wiper_setting_register}, 16'h02AA);
    send(16'h2401);
    check({15'h0000, shutdown_active}, 16'h0001);
    send(16'h1000);
    check({6'h00, wiper_setting_register}, 16'h0100);
    check({15'h0000, shutdown_active}, 16'h0000);
    send(16'h2401);
    send(16'h2400);
    check({15'h0000, shutdown_active}, 16'h0000);
    send(16'h2401);
    send(16'h06AA);
    check({6'h00, wiper_setting_register}, 16'h02AA);
    reload_pin_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    reload_pin_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    check({6'h00, wiper_setting_register}, 16'h0100);
    check({15'h0000, shutdown_active}, 16'h0000);
    send(16'h1C01);
    send(16'h06AA);
    check({6'h00, wiper_setting_register}, 16'h0100);
    $display("test reset done");
  endtask : t_reset
  task automatic t_tol;
    send(16'h1439);
    send(16'h143A);
    check(rx, 16'h008A);
    send(16'h0000);
    check(rx, 16'h00B0);
    send(16'h0000);
    check(rx, 16'h0000);
    $display("test tolerance done");
  endtask : t_tol
  task automatic t_full;
    for (int k = 2; k <= 50; k++) begin
      send(16'h0C00);
      wait_idle();
    end
    rd(16'h1800, 16'h0032);
    send(16'h0C00);
    check({14'h0000, store_busy, program_success_flag}, 16'h0000);
    rd(16'h1432, 16'h0100);
    $display("test full done");
  endtask : t_full
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge link_clk);
    t_locked();
    t_enable();
    t_store();
    t_reset();
    t_tol();
    t_full();
    conclude();
  end
endmodule : testbench
